// ===== core/lp_periph_end.sv
// Peripheral end of the low-power clock handshake, one instance per member.
// Assumes core_clk is the gated peripheral clock, or a free clock plus gate
// enable input; the request arrives from the controller's clock domain.
//
// Operation
// RULE1: controller enables clock at once on activity
// RULE2: peripheral lowers activity when clock unneeded
// RULE3: always-stoppable peripheral may tie activity low
// RULE4: peripheral needing constant clock ties activity high
// RULE5: controller holds request high, lowers to ask
// RULE6: peripheral answers low request with low acknowledge
// RULE7: exit: request rises, then acknowledge rises
// RULE8: activity level at acknowledge fall means accept/deny
// RULE9: accept: power down, drop activity, then acknowledge
// RULE10: exit: raise activity before raising acknowledge
// RULE11: after denial controller raises request before next
// RULE12: either line rising in low power starts exit
// RULE13: controller exit: clock on, request up, then activity
// RULE14: peripheral wake: controller restores clock, raises request
// RULE15: peripheral may delay acknowledge as long as needed
// RULE16: group activity is OR of members
// RULE17: one shared request line to all members
// RULE18: group acknowledge follows last member edge
// RULE19: gate clock only after low-power entry
// RULE20: controller synchronises activity and acknowledge
`timescale 1ns/1ps
module lp_periph_end
    import lp_clk_pkg::*;
#(
    parameter bit ALWAYS_ON = 1'b0,       // Needs an uninterrupted clock
    parameter bit ALWAYS_OFF = 1'b0,      // Clock may stop at any time
    parameter int unsigned DOWN_LEN = DOWN_CYCLES,
    parameter int unsigned UP_LEN = UP_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    lp_clk_if.periph lp,
    input wire logic busy,        // User logic has work and needs the clock
    input wire logic allow_sleep, // User policy: accept low-power requests
    output logic asleep           // Peripheral is in its low-power state
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    initial begin
        if (ALWAYS_ON && ALWAYS_OFF) begin
            $error("lp_periph_end: ALWAYS_ON and ALWAYS_OFF both set");
        end
        if (DOWN_LEN < 1 || UP_LEN < 1 || DOWN_LEN > 255 || UP_LEN > 255) begin
            $error("lp_periph_end: sequence lengths must be 1..255");
        end
    end

    // ------------------------------------------------------------
    // Request synchroniser
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] req_sync_q;
    logic [SYNC_STAGES-1:0] req_sync_d;
    logic req_q;
    logic req_d;

    // Shift in the request; level changes once stages two and three agree
    always_comb begin
        req_sync_d = {req_sync_q[SYNC_STAGES-2:0], lp.sys_req};
        req_d = req_q;
        if (req_sync_q[1] == req_sync_q[2]) begin
            req_d = req_sync_q[2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            req_sync_q <= {SYNC_STAGES{REQ_RUN}};
            req_q <= REQ_RUN;
        end else begin
            req_sync_q <= req_sync_d;
            req_q <= req_d;
        end
    end

    // ------------------------------------------------------------
    // Handshake state machine
    // ------------------------------------------------------------
    periph_state_t state_q;
    periph_state_t state_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic active_q;
    logic active_d;
    logic ack_q;
    logic ack_d;
    logic asleep_q;
    logic asleep_d;

    // Next state, activity and acknowledge
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        active_d = active_q;
        ack_d = ack_q;
        asleep_d = asleep_q;
        case (state_q)
            P_RUN: begin
                ack_d = ACK_RUN; // RULE6
                active_d = busy; // RULE2
                if (req_q == REQ_SLEEP) begin
                    // A member that may always stop never denies
                    if (ALWAYS_OFF || (allow_sleep && !busy && !ALWAYS_ON)) begin // RULE3
                        state_d = P_DOWN;
                        cnt_d = 8'(DOWN_LEN);
                        active_d = 1'b1;
                    end else begin
                        // Deny: acknowledge with activity held high
                        active_d = 1'b1; // RULE8
                        ack_d = 1'b0; // RULE6
                        state_d = P_DENIED;
                    end
                end
            end
            P_DOWN: begin
                // Power-down work, then activity drops before acknowledge
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (active_q) begin
                    active_d = 1'b0; // RULE9
                end else begin
                    ack_d = 1'b0; // RULE9
                    asleep_d = 1'b1; // RULE8
                    state_d = P_SLEEP;
                end
            end
            P_SLEEP: begin
                // Either side raising its line starts the exit
                if (req_q == REQ_RUN || (busy && !ALWAYS_OFF)) begin // RULE12
                    active_d = 1'b1; // RULE10
                    cnt_d = 8'(UP_LEN);
                    state_d = P_UP;
                end
            end
            P_DENIED: begin
                // Wait for the controller to close the handshake
                active_d = 1'b1;
                if (req_q == REQ_RUN) begin // RULE7
                    ack_d = ACK_RUN;
                    state_d = P_RUN;
                end
            end
            P_UP: begin
                // Power-up work; acknowledge held low meanwhile
                if (cnt_q > 8'h01) begin // RULE15
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    state_d = P_WAKE;
                end
            end
            P_WAKE: begin
                // Acknowledge only once the request is back high
                if (req_q == REQ_RUN) begin // RULE7
                    ack_d = ACK_RUN; // RULE10
                    asleep_d = 1'b0;
                    state_d = P_RUN;
                end
            end
            default: begin
                state_d = P_RUN;
                ack_d = ACK_RUN;
                active_d = 1'b1;
                asleep_d = 1'b0;
            end
        endcase
        // Fixed-activity variants override the level
        if (ALWAYS_ON) begin
            active_d = 1'b1; // RULE4
        end else if (ALWAYS_OFF) begin
            active_d = 1'b0; // RULE3
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= P_RUN;
            cnt_q <= 8'h00;
            active_q <= 1'b1;
            ack_q <= ACK_RUN;
            asleep_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            active_q <= active_d;
            ack_q <= ack_d;
            asleep_q <= asleep_d;
        end
    end

    // Register-driven outputs
    assign lp.clk_active = active_q;
    assign lp.sys_ack = ack_q;
    assign asleep = asleep_q;

endmodule : lp_periph_end

// ===== core/lp_clk_pkg.sv
// Package for the low-power clock handshake: states and timing counts.
// Assumes both ends and the bench import it whole.
package lp_clk_pkg;

    // ------------------------------------------------------------
    // Handshake levels
    // ------------------------------------------------------------
    localparam logic REQ_RUN = 1'b1;   // Request line level in normal operation
    localparam logic REQ_SLEEP = 1'b0; // Request line level asking for low power
    localparam logic ACK_RUN = 1'b1;   // Acknowledge level in normal operation

    // ------------------------------------------------------------
    // Peripheral sequence lengths and synchroniser depth, in core_clk cycles
    // ------------------------------------------------------------
    localparam int unsigned DOWN_CYCLES = 4;  // Default power-down work
    localparam int unsigned UP_CYCLES = 4;    // Default power-up work
    localparam int unsigned SYNC_STAGES = 3;  // Synchroniser depth

    // Peripheral states
    typedef enum logic [2:0] {
        P_RUN,
        P_DOWN,
        P_SLEEP,
        P_DENIED,
        P_UP,
        P_WAKE
    } periph_state_t;

    // Controller states
    typedef enum logic [1:0] {
        C_RUN,
        C_WAIT_ACK,
        C_SLEEP,
        C_WAIT_EXIT
    } ctrl_state_t;

endpackage : lp_clk_pkg

// ===== core/lp_clk_if.sv
// Interface joining the clock controller and a group of peripherals.
// Assumes one shared request line and per-member activity and acknowledge.
`timescale 1ns/1ps
interface lp_clk_if #(
    parameter int unsigned N_PERIPH = 1
);
    logic [N_PERIPH-1:0] clk_active;  // Per-member clock-needed level
    logic sys_req;                    // Shared low-power request, low asks
    logic [N_PERIPH-1:0] sys_ack;     // Per-member acknowledge

    modport periph (
        output clk_active,
        output sys_ack,
        input sys_req
    );

    modport ctrl (
        input clk_active,
        input sys_ack,
        output sys_req
    );
endinterface : lp_clk_if

// ===== core/lp_ctrl_end.sv
// System clock controller end of the low-power handshake.
// Assumes core_clk runs free; members share one request line and
// their activity and acknowledge lines arrive asynchronously.
`timescale 1ns/1ps
module lp_ctrl_end
    import lp_clk_pkg::*;
#(
    parameter int unsigned N_PERIPH = 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    lp_clk_if.ctrl lp,
    input wire logic sleep_req,  // User asks the domain to enter low power
    output logic clk_en,         // Gate enable for the domain clock
    output logic denied,         // Last request was denied (level)
    output logic asleep          // Domain is in its low-power state
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    initial begin
        if (N_PERIPH < 1) begin
            $error("lp_ctrl_end: N_PERIPH must be at least 1");
        end
    end

    // ------------------------------------------------------------
    // Synchronisers for member lines
    // ------------------------------------------------------------
    logic [N_PERIPH-1:0] act_s_q [SYNC_STAGES];
    logic [N_PERIPH-1:0] ack_s_q [SYNC_STAGES];
    logic [N_PERIPH-1:0] act_q;
    logic [N_PERIPH-1:0] act_d;
    logic [N_PERIPH-1:0] ack_q;
    logic [N_PERIPH-1:0] ack_d;

    // Per bit, take the level once stages two and three agree
    always_comb begin
        act_d = act_q;
        ack_d = ack_q;
        for (int i = 0; i < N_PERIPH; i++) begin
            if (act_s_q[1][i] == act_s_q[2][i]) begin
                act_d[i] = act_s_q[2][i]; // RULE20
            end
            if (ack_s_q[1][i] == ack_s_q[2][i]) begin
                ack_d[i] = ack_s_q[2][i]; // RULE20
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int s = 0; s < SYNC_STAGES; s++) begin
                act_s_q[s] <= '1;
                ack_s_q[s] <= '1;
            end
            act_q <= '1;
            ack_q <= '1;
        end else begin
            act_s_q[0] <= lp.clk_active;
            ack_s_q[0] <= lp.sys_ack;
            for (int s = 1; s < SYNC_STAGES; s++) begin
                act_s_q[s] <= act_s_q[s-1];
                ack_s_q[s] <= ack_s_q[s-1];
            end
            act_q <= act_d;
            ack_q <= ack_d;
        end
    end

    // ------------------------------------------------------------
    // Domain combining
    // ------------------------------------------------------------
    logic dom_active;
    logic dom_ack_low;
    logic dom_ack_high;

    assign dom_active = |act_q;   // RULE16
    assign dom_ack_low = ~|ack_q; // RULE18
    assign dom_ack_high = &ack_q; // RULE18

    // ------------------------------------------------------------
    // Controller state machine
    // ------------------------------------------------------------
    ctrl_state_t state_q;
    ctrl_state_t state_d;
    logic req_q;
    logic req_d;
    logic clk_en_q;
    logic clk_en_d;
    logic denied_q;
    logic denied_d;
    logic asleep_q;
    logic asleep_d;

    // Next request level, clock gate and status
    always_comb begin
        state_d = state_q;
        req_d = req_q;
        clk_en_d = clk_en_q;
        denied_d = denied_q;
        asleep_d = asleep_q;
        case (state_q)
            C_RUN: begin
                req_d = REQ_RUN; // RULE5
                clk_en_d = 1'b1;
                if (sleep_req && dom_ack_high) begin
                    req_d = REQ_SLEEP; // RULE5
                    denied_d = 1'b0;
                    state_d = C_WAIT_ACK;
                end
            end
            C_WAIT_ACK: begin
                // All members acknowledged; activity gives the verdict
                if (dom_ack_low) begin
                    if (dom_active) begin
                        denied_d = 1'b1;
                        req_d = REQ_RUN; // RULE11
                        state_d = C_WAIT_EXIT;
                    end else begin
                        clk_en_d = 1'b0; // RULE19
                        asleep_d = 1'b1;
                        state_d = C_SLEEP;
                    end
                end
            end
            C_SLEEP: begin
                // Wake on member activity or when user drops its request
                if (dom_active || !sleep_req) begin
                    clk_en_d = 1'b1; // RULE1 RULE14 RULE13
                    req_d = REQ_RUN; // RULE14 RULE12
                    asleep_d = 1'b0;
                    state_d = C_WAIT_EXIT;
                end
            end
            C_WAIT_EXIT: begin
                // Hold request high until every member acknowledges
                clk_en_d = 1'b1;
                if (dom_ack_high) begin // RULE7
                    state_d = C_RUN;
                end
            end
            default: begin
                state_d = C_RUN;
                req_d = REQ_RUN;
                clk_en_d = 1'b1;
                asleep_d = 1'b0;
            end
        endcase
        // Activity always forces the clock on at once
        if (dom_active) begin
            clk_en_d = 1'b1; // RULE1
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= C_RUN;
            req_q <= REQ_RUN;
            clk_en_q <= 1'b1;
            denied_q <= 1'b0;
            asleep_q <= 1'b0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            clk_en_q <= clk_en_d;
            denied_q <= denied_d;
            asleep_q <= asleep_d;
        end
    end

    // Shared request to all members and register-driven outputs
    assign lp.sys_req = req_q; // RULE17
    assign clk_en = clk_en_q;
    assign denied = denied_q;
    assign asleep = asleep_q;

endmodule : lp_ctrl_end

// ===== verif/lowpower_clock_handshake_assertions.sv
// Checker for the low-power clock handshake wires and the clock gate.
// Assumes the bench instantiates it beside the interface, one clock domain.
`timescale 1ns/1ps
module lowpower_clock_handshake_assertions #(
    parameter int unsigned N_PERIPH = 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [N_PERIPH-1:0] clk_active,
    input wire logic sys_req,
    input wire logic [N_PERIPH-1:0] sys_ack,
    input wire logic clk_en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Group views of the member lines
    logic any_act;
    logic all_ack;
    logic any_ack;
    assign any_act = |clk_active;
    assign all_ack = &sys_ack;
    assign any_ack = |sys_ack;

    // ----------------------------------------
    // Steps of the handshake
    // ----------------------------------------
    sequence s_ack_low;
        ##[1:40] !all_ack;
    endsequence
    sequence s_clk_on;
        ##[0:6] clk_en;
    endsequence

    property p_req_fall;
        $fell(sys_req) |-> $past(all_ack);
    endproperty
    property p_req_rise;
        $rose(sys_req) |-> !any_ack;
    endproperty
    property p_entry;
        $fell(sys_req) |-> s_ack_low;
    endproperty
    property p_accept;
        $fell(all_ack) && !any_act |-> $past(!any_act) && !sys_req;
    endproperty
    property p_deny;
        $fell(all_ack) && any_act |=> any_act [*3];
    endproperty
    property p_ack_rise;
        $rose(any_ack) |-> $past(sys_req) && $past(any_act);
    endproperty
    property p_clk_on;
        $rose(any_act) |-> s_clk_on;
    endproperty
    property p_gate;
        $fell(clk_en) |-> !any_ack && !sys_req && !any_act;
    endproperty
    property p_exit;
        $rose(clk_en) |-> ##[0:3] sys_req;
    endproperty

    a_req_fall: assert property (p_req_fall) else $error("request fell with ack low");
    a_req_rise: assert property (p_req_rise) else $error("request rose with ack high");
    a_entry: assert property (p_entry) else $error("no ack fall after request");
    a_accept: assert property (p_accept) else $error("accept order wrong");
    a_deny: assert property (p_deny) else $error("deny activity dropped");
    a_ack_rise: assert property (p_ack_rise) else $error("exit order wrong");
    a_clk_on: assert property (p_clk_on) else $error("clock not enabled on activity");
    a_gate: assert property (p_gate) else $error("clock gated before low power");
    a_exit: assert property (p_exit) else $error("request not raised on clock restore");
endmodule : lowpower_clock_handshake_assertions

// ===== verif/lowpower_clock_handshake_test.sv
// Self-checking bench: controller end and one peripheral end face to face, plus a second controller with a two-member group.
// Assumes both ends run on the free core_clk; the checker watches the wires.
`timescale 1ns/1ps
module lowpower_clock_handshake_test
    import lp_clk_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic busy = 1'b0;
    logic allow_sleep = 1'b0;
    logic sleep_req = 1'b0;
    logic p_asleep, clk_en, denied, c_asleep;
    logic ack_q = 1'b1;
    logic exp_q[$];
    logic sleep_req_g = 1'b0;
    logic clk_en_g, denied_g, asleep_g, asleep_off, asleep_on;
    logic grp_ack_q = 1'b1;
    logic exp_g[$];
    int err_count = 0;
    int tests_run = 0;
    int seed = 32'h7473;

    lp_clk_if #(.N_PERIPH(1)) lp ();
    lp_periph_end lp_periph_end_i (.core_clk(core_clk), .sys_rst(sys_rst), .lp(lp),
        .busy(busy), .allow_sleep(allow_sleep), .asleep(p_asleep));
    lp_ctrl_end #(.N_PERIPH(1)) lp_ctrl_end_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .lp(lp), .sleep_req(sleep_req), .clk_en(clk_en), .denied(denied),
        .asleep(c_asleep));
    lowpower_clock_handshake_assertions #(.N_PERIPH(1)) chk_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .clk_active(lp.clk_active), .sys_req(lp.sys_req),
        .sys_ack(lp.sys_ack), .clk_en(clk_en));

    // Grouped domain: a stoppable member and an always-clocked member
    lp_clk_if #(.N_PERIPH(1)) lp_off ();
    lp_clk_if #(.N_PERIPH(1)) lp_on ();
    lp_clk_if #(.N_PERIPH(2)) lp_g ();
    assign lp_g.clk_active = {lp_on.clk_active, lp_off.clk_active};
    assign lp_g.sys_ack = {lp_on.sys_ack, lp_off.sys_ack};
    assign lp_off.sys_req = lp_g.sys_req;
    assign lp_on.sys_req = lp_g.sys_req;
    lp_periph_end #(.ALWAYS_OFF(1'b1), .DOWN_LEN(9)) lp_periph_end_off_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .lp(lp_off), .busy(busy),
        .allow_sleep(allow_sleep), .asleep(asleep_off));
    lp_periph_end #(.ALWAYS_ON(1'b1)) lp_periph_end_on_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .lp(lp_on), .busy(busy), .allow_sleep(allow_sleep),
        .asleep(asleep_on));
    lp_ctrl_end #(.N_PERIPH(2)) lp_ctrl_end_grp_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .lp(lp_g), .sleep_req(sleep_req_g), .clk_en(clk_en_g), .denied(denied_g),
        .asleep(asleep_g));

    // Free-running clock, 10 ns period
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Compare and finish
    // ----------------------------------------
    task automatic chk(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // Select a watched output by number
    function automatic logic probe(input int k);
        case (k)
            0: return lp.sys_ack[0];
            1: return clk_en;
            2: return lp.sys_req;
            3: return lp_on.sys_ack[0];
            4: return lp_g.sys_req;
            default: return &lp_g.sys_ack;
        endcase
    endfunction : probe

    // Bounded wait for an output level
    task automatic wait_for(input int k, input logic v, input string name);
        int n;
        n = 0;
        while (probe(k) !== v && n < 80) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 80) begin
            err_count++;
            $display("Error %s expected %b seen timeout", name, v);
            report_and_stop();
        end
    endtask : wait_for

    // Activity level at each acknowledge fall against the oldest note
    always @(posedge core_clk) begin
        ack_q <= lp.sys_ack[0];
        grp_ack_q <= &lp_g.sys_ack;
        if (!sys_rst && grp_ack_q === 1'b1 && (&lp_g.sys_ack) === 1'b0) begin
            if (exp_g.size() == 0) begin
                err_count++;
                $display("Error grp_ack_fall expected none seen 0");
            end else begin
                chk("grp_clk_active", exp_g.pop_front(), |lp_g.clk_active);
            end
        end
        if (!sys_rst && ack_q === 1'b1 && lp.sys_ack[0] === 1'b0) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("Error ack_fall expected none seen 0");
            end else begin
                chk("clk_active", exp_q.pop_front(), lp.clk_active[0]);
            end
        end
    end

    // ----------------------------------------
    // One request, answer and exit
    // ----------------------------------------
    task automatic run_round(input logic b, input logic a, input logic w);
        logic acc;
        acc = !b && a;
        busy = b;
        allow_sleep = a;
        repeat (2) @(posedge core_clk);
        #1;
        exp_q.push_back(!acc);
        sleep_req = 1'b1;
        wait_for(0, 1'b0, "sys_ack_fall");
        if (acc) begin
            wait_for(1, 1'b0, "clk_en_off");
            chk("ctrl_asleep", 1'b1, c_asleep);
            chk("periph_asleep", 1'b1, p_asleep);
            if (w) begin
                busy = 1'b1;
            end else begin
                sleep_req = 1'b0;
            end
            wait_for(1, 1'b1, "clk_en_on");
            if (w) begin
                sleep_req = 1'b0;
            end
        end else begin
            wait_for(2, 1'b1, "sys_req_rise");
            chk("denied", 1'b1, denied);
            sleep_req = 1'b0;
        end
        wait_for(0, ACK_RUN, "sys_ack_rise");
        chk("sys_req", REQ_RUN, lp.sys_req);
        chk("clk_active", 1'b1, lp.clk_active[0]);
        chk("periph_asleep", 1'b0, p_asleep);
        chk("ctrl_asleep", 1'b0, c_asleep);
        repeat (SYNC_STAGES + 2) @(posedge core_clk);
        #1;
        $display("Round done busy %b allow %b wake %b", b, a, w);
    endtask : run_round

    // ----------------------------------------
    // Grouped domain: one member denies, one accepts
    // ----------------------------------------
    task automatic run_group();
        busy = 1'b0;
        allow_sleep = 1'b1;
        exp_g.push_back(1'b1);
        sleep_req_g = 1'b1;
        wait_for(3, 1'b0, "on_sys_ack_fall");
        repeat (SYNC_STAGES + 2) @(posedge core_clk);
        #1;
        chk("off_sys_ack", 1'b1, lp_off.sys_ack[0]);
        chk("grp_sys_req", REQ_SLEEP, lp_g.sys_req);
        chk("off_clk_active", 1'b0, lp_off.clk_active[0]);
        wait_for(4, REQ_RUN, "grp_sys_req_rise");
        chk("grp_denied", 1'b1, denied_g);
        chk("grp_clk_en", 1'b1, clk_en_g);
        chk("on_clk_active", 1'b1, lp_on.clk_active[0]);
        chk("off_asleep", 1'b1, asleep_off);
        sleep_req_g = 1'b0;
        wait_for(5, ACK_RUN, "grp_sys_ack_rise");
        chk("off_asleep", 1'b0, asleep_off);
        chk("on_asleep", 1'b0, asleep_on);
        chk("grp_asleep", 1'b0, asleep_g);
        chk("off_clk_active", 1'b0, lp_off.clk_active[0]);
        repeat (SYNC_STAGES + 2) @(posedge core_clk);
        #1;
        $display("Group round done");
    endtask : run_group

    // Idle levels after reset
    task automatic check_idle();
        chk("sys_req", REQ_RUN, lp.sys_req);
        chk("sys_ack", ACK_RUN, lp.sys_ack[0]);
        chk("clk_en", 1'b1, clk_en);
        chk("denied", 1'b0, denied);
        chk("ctrl_asleep", 1'b0, c_asleep);
        chk("periph_asleep", 1'b0, p_asleep);
    endtask : check_idle

    // Main sequence: fixed cases, then seeded random rounds, then the group round, then a reset
    initial begin
        logic b, a, w;
        repeat (3) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        check_idle();
        for (int i = 0; i < 10; i++) begin
            case (i)
                0: {b, a, w} = 3'b010;
                1: {b, a, w} = 3'b110;
                2: {b, a, w} = 3'b000;
                3: {b, a, w} = 3'b011;
                default: {b, a, w} = 3'($random(seed));
            endcase
            run_round(b, a, w);
        end
        run_group();
        busy = 1'b0;
        allow_sleep = 1'b1;
        sleep_req = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        sys_rst = 1'b1;
        sleep_req = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        check_idle();
        run_round(1'b0, 1'b1, 1'b0);
        $display("Mid-run reset test done");
        report_and_stop();
    end
endmodule : lowpower_clock_handshake_test
